// ===== src/aocr_pkg.sv
// Purpose: Constants for the converter output configuration register bank.
// Assumes: 8-bit registers on an 8-bit-wide address port.
// Notes: Offsets are the register addresses of the serial control port.
package aocr_pkg;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFFS_OFFSET_TRIM = 8'h10;
  localparam logic [7:0] OFFS_FORMAT_CTL = 8'h14;
  localparam logic [7:0] OFFS_DRIVE = 8'h15;
  localparam logic [7:0] OFFS_CLK_PHASE = 8'h16;
  localparam logic [7:0] OFFS_FINE_DELAY = 8'h17;
  localparam logic [7:0] OFFS_REF_SPAN = 8'h18;
  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_OFFSET_TRIM = 8'h00;
  localparam logic [7:0] RST_FORMAT_CTL = 8'h00;
  localparam logic [7:0] RST_DRIVE = 8'h22;
  localparam logic [7:0] RST_CLK_PHASE = 8'h00;
  localparam logic [7:0] RST_FINE_DELAY = 8'h00;
  localparam logic [7:0] RST_REF_SPAN = 8'hE0;
  // ----------------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------------
  localparam int FMT_INVERT_BIT = 2;
  localparam int FMT_DISABLE_BIT = 4;
  localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
  localparam logic [1:0] FMT_TWOS_COMP = 2'h1;
  localparam logic [1:0] FMT_GRAY = 2'h2;
  localparam int PHASE_POL_BIT = 7;
  localparam logic [2:0] PHASE_MAX = 3'h6;
  localparam int DLY_CLK_EN_BIT = 7;
  localparam int DLY_DATA_EN_BIT = 5;
  // Writable bit masks; open bits read zero, reserved span bits read one.
  localparam logic [7:0] MASK_FORMAT_CTL = 8'hD7;
  localparam logic [7:0] MASK_CLK_PHASE = 8'h87;
  localparam logic [7:0] MASK_FINE_DELAY = 8'hA7;
  localparam logic [7:0] MASK_REF_SPAN = 8'h38;
  localparam logic [7:0] FIXED_REF_SPAN = 8'hC0;
  // Converter data width and full-scale codes.
  localparam int DATA_W = 10;
  localparam logic signed [11:0] CODE_MAX = 12'sh3FF;
  localparam logic signed [11:0] CODE_MIN = 12'sh000;
endpackage : aocr_pkg

// ===== src/aocr_regs.sv
// Purpose: Output configuration registers and output formatting of the converter.
// Assumes: Register port is synchronous to i_core_clk; one access per cycle.
// Notes: Fine delay code is exported to the pad delay lines, not modelled here.
//
// Functional notes
// [R1] Signed trim added to conversion result, saturated.
// [R2] Format select, invert and disable outputs.
// [R3] Divider phase 0..6 selects output clock; invert.
// [R4] Phase changes only the output clock.
// [R5] Delay code applies only where enable set.
`timescale 1ns/1ns
`default_nettype none
module aocr_regs (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Converter core side
  input wire logic i_sample_valid,
  input wire logic [9:0] i_sample,
  input wire logic [6:0] i_div_phases,
  // Formatted outputs
  output logic [9:0] o_data,
  output logic o_data_oe,
  output logic o_output_data_clock,
  output logic [2:0] o_clk_delay_code,
  output logic [2:0] o_data_delay_code,
  output logic [7:0] o_drive_strength,
  output logic [2:0] o_ref_span_code
);
  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [7:0] offset_trim_ff; // Signed offset in LSBs.
  logic [7:0] format_ctl_ff; // Format, invert and disable.
  logic [7:0] drive_ff; // Pad drive strength.
  logic [7:0] clk_phase_ff; // Clock phase and polarity.
  logic [7:0] fine_delay_ff; // Fine delay and enables.
  logic [7:0] ref_span_ff; // Reference span select.
  logic [7:0] rdata_ff; // Read data holding register.
  logic [9:0] data_ff; // Formatted output word.
  logic dclk_ff; // Registered output clock.

  // Writes to each register; unwritable bits are masked off.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      offset_trim_ff <= aocr_pkg::RST_OFFSET_TRIM;
      format_ctl_ff <= aocr_pkg::RST_FORMAT_CTL;
      drive_ff <= aocr_pkg::RST_DRIVE;
      clk_phase_ff <= aocr_pkg::RST_CLK_PHASE;
      fine_delay_ff <= aocr_pkg::RST_FINE_DELAY;
      ref_span_ff <= aocr_pkg::RST_REF_SPAN;
    end else if (i_reg_wr) begin
      if (i_reg_addr == aocr_pkg::OFFS_OFFSET_TRIM) begin
        offset_trim_ff <= i_reg_wdata;
      end else if (i_reg_addr == aocr_pkg::OFFS_FORMAT_CTL) begin
        format_ctl_ff <= i_reg_wdata & aocr_pkg::MASK_FORMAT_CTL;
      end else if (i_reg_addr == aocr_pkg::OFFS_DRIVE) begin
        drive_ff <= i_reg_wdata;
      end else if (i_reg_addr == aocr_pkg::OFFS_CLK_PHASE) begin
        clk_phase_ff <= i_reg_wdata & aocr_pkg::MASK_CLK_PHASE;
      end else if (i_reg_addr == aocr_pkg::OFFS_FINE_DELAY) begin
        fine_delay_ff <= i_reg_wdata & aocr_pkg::MASK_FINE_DELAY;
      end else if (i_reg_addr == aocr_pkg::OFFS_REF_SPAN) begin
        ref_span_ff <= (i_reg_wdata & aocr_pkg::MASK_REF_SPAN) | aocr_pkg::FIXED_REF_SPAN;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [7:0] nxt_rdata;
  // Unmapped addresses read zero.
  always_comb begin
    if (i_reg_addr == aocr_pkg::OFFS_OFFSET_TRIM) begin
      nxt_rdata = offset_trim_ff;
    end else if (i_reg_addr == aocr_pkg::OFFS_FORMAT_CTL) begin
      nxt_rdata = format_ctl_ff;
    end else if (i_reg_addr == aocr_pkg::OFFS_DRIVE) begin
      nxt_rdata = drive_ff;
    end else if (i_reg_addr == aocr_pkg::OFFS_CLK_PHASE) begin
      nxt_rdata = clk_phase_ff;
    end else if (i_reg_addr == aocr_pkg::OFFS_FINE_DELAY) begin
      nxt_rdata = fine_delay_ff;
    end else if (i_reg_addr == aocr_pkg::OFFS_REF_SPAN) begin
      nxt_rdata = ref_span_ff;
    end else begin
      nxt_rdata = 8'h00;
    end
  end

  // Read data is captured on a read strobe and held until the next one.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_ff <= 8'h00;
    end else if (i_reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign o_reg_rdata = rdata_ff;

  // ----------------------------------------------------------------------
  // Data formatting
  // ----------------------------------------------------------------------
  logic signed [11:0] trimmed; // Sample plus signed offset.
  logic [9:0] clamped; // Trimmed value held in range.
  logic [9:0] coded; // Value in selected encoding.
  logic [9:0] nxt_data;
  always_comb begin
    trimmed = $signed({2'h0, i_sample}) + 12'($signed(offset_trim_ff)); // see [R1]
    if (trimmed > aocr_pkg::CODE_MAX) begin
      clamped = 10'h3FF;
    end else if (trimmed < aocr_pkg::CODE_MIN) begin
      clamped = 10'h000;
    end else begin
      clamped = trimmed[9:0];
    end
    case (format_ctl_ff[1:0]) // see [R2]
      aocr_pkg::FMT_TWOS_COMP: coded = {~clamped[9], clamped[8:0]};
      aocr_pkg::FMT_GRAY: coded = clamped ^ (clamped >> 1);
      default: coded = clamped;
    endcase
    nxt_data = format_ctl_ff[aocr_pkg::FMT_INVERT_BIT] ? ~coded : coded; // see [R2]
  end

  // Output word updates on each valid sample; sampling timing never moves.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      data_ff <= 10'h000;
    end else if (i_sample_valid) begin
      data_ff <= nxt_data; // see [R4]
    end
  end
  assign o_data = data_ff;
  assign o_data_oe = ~format_ctl_ff[aocr_pkg::FMT_DISABLE_BIT]; // see [R2]

  // ----------------------------------------------------------------------
  // Output clock phase
  // ----------------------------------------------------------------------
  logic [2:0] phase_sel;
  logic nxt_dclk;
  always_comb begin
    // Codes above six are treated as six.
    phase_sel = (clk_phase_ff[2:0] > aocr_pkg::PHASE_MAX) ? aocr_pkg::PHASE_MAX
                                                           : clk_phase_ff[2:0];
    nxt_dclk = i_div_phases[phase_sel] ^ clk_phase_ff[aocr_pkg::PHASE_POL_BIT]; // see [R3]
  end

  // Only the presented clock follows the phase choice.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      dclk_ff <= 1'b0;
    end else begin
      dclk_ff <= nxt_dclk; // see [R4]
    end
  end
  assign o_output_data_clock = dclk_ff;

  // ----------------------------------------------------------------------
  // Fine delay, drive and reference
  // ----------------------------------------------------------------------
  assign o_clk_delay_code = fine_delay_ff[aocr_pkg::DLY_CLK_EN_BIT] ? fine_delay_ff[2:0]
                                                                    : 3'h0; // see [R5]
  assign o_data_delay_code = fine_delay_ff[aocr_pkg::DLY_DATA_EN_BIT] ? fine_delay_ff[2:0]
                                                                      : 3'h0; // see [R5]
  assign o_drive_strength = drive_ff;
  // The span code sits in bits 5:3; bits 7:6 always read as ones and bits 2:0 stay zero.
  assign o_ref_span_code = ref_span_ff[5:3];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  trim_zero_pass_a: assert property ( // see [R1]
    (i_sample_valid && offset_trim_ff == 8'h00 && format_ctl_ff == 8'h00)
      |=> o_data == $past(i_sample))
    else $error("Zero trim changed the sample.");
  disable_oe_a: assert property ( // see [R2]
    o_data_oe == !format_ctl_ff[aocr_pkg::FMT_DISABLE_BIT])
    else $error("Output enable disagrees with disable bit.");
  invert_data_a: assert property ( // see [R2]
    (i_sample_valid && format_ctl_ff == 8'h04 && offset_trim_ff == 8'h00)
      |=> o_data == ~$past(i_sample))
    else $error("Inverted output is wrong.");
  phase_pick_a: assert property ( // see [R3]
    (clk_phase_ff == 8'h03) |=> o_output_data_clock == $past(i_div_phases[3]))
    else $error("Output clock phase wrong.");
  data_hold_a: assert property ( // see [R4]
    !i_sample_valid |=> $stable(o_data))
    else $error("Output data moved without a sample.");
  clk_dly_gate_a: assert property ( // see [R5]
    !fine_delay_ff[aocr_pkg::DLY_CLK_EN_BIT] |-> o_clk_delay_code == 3'h0)
    else $error("Clock delay applied while disabled.");
  data_dly_gate_a: assert property ( // see [R5]
    fine_delay_ff[aocr_pkg::DLY_DATA_EN_BIT] |-> o_data_delay_code == fine_delay_ff[2:0])
    else $error("Data delay code not applied.");
  trim_write_a: assert property ( // see [R1]
    (i_reg_wr && i_reg_addr == aocr_pkg::OFFS_OFFSET_TRIM) |=> offset_trim_ff == $past(i_reg_wdata))
    else $error("Offset trim write lost.");
  // The checks below pin the two's complement encoding with a zero trim, the clamped phase code and the inverted clock polarity.
  twos_flip_a: assert property ( // see [R2]
    (i_sample_valid && format_ctl_ff == 8'h01 && offset_trim_ff == 8'h00)
      |=> o_data == {~$past(i_sample[9]), $past(i_sample[8:0])})
    else $error("Twos complement output is wrong.");
  phase_clamp_a: assert property ( // see [R3]
    (clk_phase_ff[2:0] == 3'h7)
      |=> o_output_data_clock == $past(i_div_phases[6] ^ clk_phase_ff[7]))
    else $error("Phase code seven did not pick phase six.");
  polarity_inv_a: assert property ( // see [R3]
    (clk_phase_ff == 8'h80) |=> o_output_data_clock == !$past(i_div_phases[0]))
    else $error("Output clock polarity not inverted.");
  // Cover points for the main formatting and output scenarios.
  disable_cov: cover property (!o_data_oe);
  gray_cov: cover property (i_sample_valid && format_ctl_ff[1:0] == aocr_pkg::FMT_GRAY);
  neg_trim_cov: cover property (i_sample_valid && offset_trim_ff[7]);
  pol_cov: cover property (clk_phase_ff[aocr_pkg::PHASE_POL_BIT] && clk_phase_ff[2:0] == 3'h6);
endmodule : aocr_regs
`default_nettype wire

// ===== test/aocr_host_model.sv
// Purpose: Host model that drives the register port of the bank.
// Assumes: Each access is launched just after a rising clock edge.
// Notes: Idle lines show inverted values, so stale bytes never look valid.
`timescale 1ns/1ns
`default_nettype none
module aocr_host_model (
  // Clock
  input wire logic i_core_clk,
  // Register port
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata
);
  // The port is quiet at time zero.
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end
  // One access, held to its taking edge; read data is taken just after it.
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    o_reg_wr = wr;
    o_reg_rd = ~wr;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(posedge i_core_clk);
    #1;
    q = i_reg_rdata;
  endtask : access
  // Drops the strobes and scrambles address and data.
  task automatic idle();
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = ~o_reg_addr;
    o_reg_wdata = ~o_reg_wdata;
  endtask : idle
endmodule : aocr_host_model
`default_nettype wire

// ===== test/test_adc_output_config_registers.sv
// Purpose: Self-checking bench of the output configuration registers.
// Assumes: Host model drives the register port.
// Notes: Random trims, formats, phases and samples from a fixed seed.
`timescale 1ns/1ns
`default_nettype none
module test_adc_output_config_registers;
  logic i_core_clk, i_reset, wr, rd, sv, oe, oclk;
  logic [7:0] addr, wd, rdat, drv, q, t, f, p, d;
  logic [9:0] s, data;
  logic [6:0] ph;
  logic [2:0] cdly, ddly, span;
  int fails = 0, check_count = 0, seed = 7278, k;
  logic [7:0] adr [6] = '{8'h10, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18};
  logic [7:0] rst [6] = '{8'h00, 8'h00, 8'h22, 8'h00, 8'h00, 8'hE0};
  logic [7:0] one [6] = '{8'hFF, 8'hD7, 8'hFF, 8'h87, 8'hA7, 8'hF8};
  // Design and host.
  aocr_regs dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat),
    .i_sample_valid(sv), .i_sample(s), .i_div_phases(ph), .o_data(data),
    .o_data_oe(oe), .o_output_data_clock(oclk), .o_clk_delay_code(cdly),
    .o_data_delay_code(ddly), .o_drive_strength(drv), .o_ref_span_code(span));
  aocr_host_model host (.i_core_clk(i_core_clk), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_addr(addr), .o_reg_wdata(wd), .i_reg_rdata(rdat));
  // 250 MHz clock.
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("fails=%0d checks=%0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // Expected output word: saturated trim, encoding, then inversion.
  function automatic logic [9:0] exp_data(input logic [9:0] s, input logic [7:0] t,
                                          input logic [7:0] f);
    int v;
    logic [9:0] b;
    v = int'(s) + int'($signed(t));
    b = (v < 0) ? 10'h000 : (v > 1023) ? 10'h3FF : v[9:0];
    if (f[1:0] == 2'h1) b[9] = ~b[9];
    else if (f[1:0] == 2'h2) b = b ^ (b >> 1);
    if (f[2]) b = ~b;
    return b;
  endfunction : exp_data
  // Watchdog against a hang.
  initial begin
    #100000;
    fails++;
    summarize();
  end
  // Main sequence.
  initial begin
    i_reset = 1'b1;
    sv = 1'b0;
    s = 10'h000;
    ph = 7'h00;
    repeat (16) @(posedge i_core_clk);
    #1 i_reset = 1'b0;
    chk({oe, drv, span}, {1'b1, 8'h22, 3'h4});
    chk({data, oclk, cdly, ddly}, {10'h000, 1'b0, 3'h0, 3'h0});
    for (k = 0; k < 6; k++) begin
      host.access(1'b0, adr[k], 8'h00, q);
      chk(q, rst[k]);
    end
    host.access(1'b0, 8'h11, 8'h00, q);
    chk(q, 8'h00);
    for (k = 0; k < 6; k++) host.access(1'b1, adr[k], 8'hFF, q);
    for (k = 0; k < 6; k++) begin
      host.access(1'b0, adr[k], 8'h00, q);
      chk(q, one[k]);
    end
    host.idle();
    chk({oe, cdly, ddly, span, drv}, {1'b0, 3'h7, 3'h7, 3'h7, 8'hFF});
    $display("test registers done");
    for (k = 0; k < 40; k++) begin
      t = $random(seed);
      s = $random(seed);
      if (k == 0) {t, s} = {8'h7F, 10'h3F0};
      if (k == 1) {t, s} = {8'h80, 10'h005};
      f = $random(seed) & 8'h07;
      p = $random(seed) & 8'h87;
      if (k == 2) {t, f, p} = {8'h00, 8'h00, 8'h03};
      if (k == 3) {t, f, p} = {8'h00, 8'h04, 8'h80};
      if (k == 4) {t, f, p} = {8'h00, 8'h01, 8'h07};
      d = $random(seed);
      host.access(1'b1, 8'h10, t, q);
      host.access(1'b1, 8'h14, f, q);
      host.access(1'b1, 8'h16, p, q);
      host.access(1'b1, 8'h17, d, q);
      host.idle();
      sv = 1'b1;
      ph = $random(seed);
      @(posedge i_core_clk);
      #1 sv = 1'b0;
      chk(data, exp_data(s, t, f));
      chk(oclk, ph[(p[2:0] > 6) ? 3'h6 : p[2:0]] ^ p[7]);
      chk({oe, cdly, ddly}, {1'b1, d[7] ? d[2:0] : 3'h0, d[5] ? d[2:0] : 3'h0});
      ph = ~ph;
      @(posedge i_core_clk);
      #1 chk(data, exp_data(s, t, f));
      chk(oclk, ph[(p[2:0] > 6) ? 3'h6 : p[2:0]] ^ p[7]);
    end
    $display("test data path done");
    summarize();
  end
endmodule : test_adc_output_config_registers
`default_nettype wire
